// ### pkg/ramp_seq_params.svh
// constants of the frequency ramp sequencer: offsets, field positions, codes, counts
// What this block does
// - Ramp-type field picks waveform; ramping begins only when the start bit reads one.
// - Dual-rate bit one: alternate two ramps, each with own steps and deviation.
// - Deviation select bit steers word and shift into set zero or set one.
// - Step select bit steers the step count into ramp one or ramp two.
// - New settings for one ramp are taken while the other ramp runs.
// - Ramp-with-FSK bit one: FSK deviation is superimposed on the running ramp.
// - With FSK, set one gives the FSK offset; set zero gives the ramp its deviation and step count.
// - Delayed-start bit one: wait the programmed delay after start before ramping.
// - Scaling bit zero: delay is delay word times one phase-detector period.
// - Scaling bit one: delay is word times first divider times one period.
// - Delay-between bit one: programmed delay is inserted between successive ramps.
// - Fast-lock-on-delay bit one: fast lock is asserted during the delay between ramps.
// - Dual-rate and delay-between together: delay inserted while alternating the rate sets.
// - Parabolic mode: each step adds step index times the deviation.
// - Triangle with dual rate off uses the same step count up then down: twice the sweep time.
// - Hop interval is first divider times second divider phase-detector periods in ramp divider mode; otherwise first divider periods.
// - Each hop adds or subtracts the deviation word shifted left by the shift.
// - Sawtooth restores the initial divider on the interval after the last step.
`ifndef RAMP_SEQ_PARAMS_SVH
`define RAMP_SEQ_PARAMS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define RS_OFF_STATUS 8'h20
`define RS_OFF_NDIV_LO 8'h24
`define RS_OFF_NDIV_HI 8'h28
`define RS_REG_COUNT 8

// ----------------------------------------
// field positions
// ----------------------------------------
`define RS_START_BIT 31
`define RS_INT_HI 26
`define RS_INT_LO 15
`define RS_FRACM_HI 14
`define RS_FRACM_LO 3
`define RS_FRACL_HI 27
`define RS_FRACL_LO 15
`define RS_FIRST_TIMER_DIVIDER_HI 14
`define RS_FIRST_TIMER_DIVIDER_LO 3
`define RS_TYPE_HI 11
`define RS_TYPE_LO 10
`define RS_SECOND_TIMER_DIVIDER_HI 18
`define RS_SECOND_TIMER_DIVIDER_LO 7
`define RS_DIVMODE_HI 20
`define RS_DIVMODE_LO 19
`define RS_CLKSEL_BIT 6
`define RS_DEV_HI 18
`define RS_DEV_LO 3
`define RS_SHIFT_HI 22
`define RS_SHIFT_LO 19
`define RS_SEL_BIT 23
`define RS_DUAL_BIT 24
`define RS_FSK_BIT 25
`define RS_PARAB_BIT 28
`define RS_STEP_HI 22
`define RS_STEP_LO 3
`define RS_DLY_HI 14
`define RS_DLY_LO 3
`define RS_DLYSTART_BIT 15
`define RS_DLYSCALE_BIT 16
`define RS_DLYBETWEEN_BIT 17
`define RS_FASTLOCK_BIT 18

// ----------------------------------------
// codes, reset values and timing counts
// ----------------------------------------
`define RS_DIVMODE_RAMP 2'h3
`define RS_REG_RESET 32'h0000_0000
`define RS_AXI_OKAY 2'h0
`define RS_AXI_SLVERR 2'h2
`define RS_PFD_RATIO 4

`endif

// ### pkg/ramp_seq_pkg.sv
// types shared by the frequency ramp sequencer files
package ramp_seq_pkg;

  // waveform selector codes
  typedef enum logic [1:0] {
    WAVE_SAW = 2'h0,
    WAVE_TRI = 2'h1,
    WAVE_SAW_BURST = 2'h2,
    WAVE_RAMP_BURST = 2'h3
  } waveType_t;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DELAY = 4'h2,
    ST_RAMP = 4'h4,
    ST_HOLD = 4'h8
  } seqState_t;

  // one ramp's rate set
  typedef struct packed {
    logic [15:0] devWord;
    logic [3:0] devShift;
    logic [19:0] steps;
    logic [11:0] second_timer_divider;
  } rateSet_t;

  // two-stage divider chain settings of the interval timer
  typedef struct packed {
    logic [11:0] divA;
    logic [11:0] divB;
  } timerCfg_t;

endpackage

// ### core/ramp_interval_timer.sv
// interval timer: expires after divA times divB enable ticks
module ramp_interval_timer (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tickEn,
  input wire logic restart,
  input ramp_seq_pkg::timerCfg_t cfg,
  output logic expire
);

  logic [11:0] innerCnt_q;
  logic [11:0] outerCnt_q;

  // nested count; a zero divider behaves as one so the timer never stalls
  always_ff @(posedge clk_sys) begin
    if (sys_rst || restart) begin
      innerCnt_q <= 12'h001;
      outerCnt_q <= 12'h001;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (tickEn) begin
        if (innerCnt_q >= cfg.divA) begin
          innerCnt_q <= 12'h001;
          if (outerCnt_q >= cfg.divB) begin
            outerCnt_q <= 12'h001;
            expire <= 1'b1;
          end else begin
            outerCnt_q <= outerCnt_q + 12'h001;
          end
        end else begin
          innerCnt_q <= innerCnt_q + 12'h001;
        end
      end
    end
  end

endmodule

// ### core/frequency_ramp_sequencer.sv
// frequency ramp sequencer with AXI4-Lite register access
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`include "ramp_seq_params.svh"

module frequency_ramp_sequencer #(
  parameter int PFD_RATIO = `RS_PFD_RATIO
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic txData,
  output logic [36:0] nDivider,
  output logic rampActive,
  output logic fastLock
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // signed deviation word shifted into divider units
  function automatic logic signed [36:0] devInc(input logic [15:0] w, input logic [3:0] s);
    logic signed [36:0] ext;
    ext = 37'(signed'(w));
    return ext <<< s;
  endfunction

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] strbMerge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // phase-detector rate enable
  // ----------------------------------------
  logic [15:0] pfdCnt_q;
  logic pfdTick_q;

  // all ramp timing runs from this one-cycle enable
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pfdCnt_q <= 16'h0000;
      pfdTick_q <= 1'b0;
    end else if (pfdCnt_q >= 16'(PFD_RATIO - 1)) begin
      pfdCnt_q <= 16'h0000;
      pfdTick_q <= 1'b1;
    end else begin
      pfdCnt_q <= pfdCnt_q + 16'h0001;
      pfdTick_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  logic awHeld_q;
  logic wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  logic [2:0] wIdx;
  logic wMapped;
  logic [31:0] wMerged;
  logic [31:0] regRaw_q [`RS_REG_COUNT];
  ramp_seq_pkg::rateSet_t rate_q [2];

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wIdx = awAddr_q[4:2];
  assign wMapped = awAddr_q[7:5] == 3'h0 && awAddr_q[1:0] == 2'h0;
  assign wMerged = strbMerge(regRaw_q[wIdx], wData_q, wStrb_q);

  // address and data are taken in either order; response after both
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RS_AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wMapped ? `RS_AXI_OKAY : `RS_AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // raw register images; the host orders its writes, no ordering is checked here
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < `RS_REG_COUNT; i++) begin
        regRaw_q[i] <= `RS_REG_RESET;
      end
    end else if (doWrite && wMapped) begin
      regRaw_q[wIdx] <= wMerged;
    end
  end

  // two rate sets; the select bit picks the target, the other set is untouched
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rate_q[0] <= '0;
      rate_q[1] <= '0;
    end else if (doWrite && wMapped) begin
      case (wIdx)
        3'h4: begin
          rate_q[wMerged[`RS_CLKSEL_BIT]].second_timer_divider <= wMerged[`RS_SECOND_TIMER_DIVIDER_HI:`RS_SECOND_TIMER_DIVIDER_LO];
        end
        3'h5: begin
          rate_q[wMerged[`RS_SEL_BIT]].devWord <= wMerged[`RS_DEV_HI:`RS_DEV_LO];
          rate_q[wMerged[`RS_SEL_BIT]].devShift <= wMerged[`RS_SHIFT_HI:`RS_SHIFT_LO];
        end
        3'h6: begin
          rate_q[wMerged[`RS_SEL_BIT]].steps <= wMerged[`RS_STEP_HI:`RS_STEP_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  logic [36:0] baseDiv;
  ramp_seq_pkg::waveType_t waveType;
  logic [11:0] first_timer_divider;
  logic rampDivMode;
  logic dualOn;
  logic fskOn;
  logic parabOn;
  logic dlyStartOn;
  logic dlyScaleOn;
  logic dlyBetweenOn;
  logic fastLockOn;
  logic startBit;
  logic startPulse;

  assign baseDiv = {regRaw_q[0][`RS_INT_HI:`RS_INT_LO], regRaw_q[0][`RS_FRACM_HI:`RS_FRACM_LO],
                    regRaw_q[1][`RS_FRACL_HI:`RS_FRACL_LO]};
  assign waveType = ramp_seq_pkg::waveType_t'(regRaw_q[3][`RS_TYPE_HI:`RS_TYPE_LO]);
  assign first_timer_divider = regRaw_q[2][`RS_FIRST_TIMER_DIVIDER_HI:`RS_FIRST_TIMER_DIVIDER_LO];
  assign rampDivMode = regRaw_q[4][`RS_DIVMODE_HI:`RS_DIVMODE_LO] == `RS_DIVMODE_RAMP;
  assign dualOn = regRaw_q[5][`RS_DUAL_BIT];
  assign fskOn = regRaw_q[5][`RS_FSK_BIT];
  assign parabOn = regRaw_q[5][`RS_PARAB_BIT];
  assign dlyStartOn = regRaw_q[7][`RS_DLYSTART_BIT];
  assign dlyScaleOn = regRaw_q[7][`RS_DLYSCALE_BIT];
  assign dlyBetweenOn = regRaw_q[7][`RS_DLYBETWEEN_BIT];
  assign fastLockOn = regRaw_q[7][`RS_FASTLOCK_BIT];
  assign startBit = regRaw_q[0][`RS_START_BIT];
  // each write of the start bit as one (re)starts the sweep
  assign startPulse = doWrite && wMapped && wIdx == 3'h0 && wMerged[`RS_START_BIT];

  // ----------------------------------------
  // step and delay timers
  // ----------------------------------------
  ramp_seq_pkg::seqState_t state_q;
  logic rampSel_q;
  logic activeSet;
  ramp_seq_pkg::timerCfg_t stepCfg;
  ramp_seq_pkg::timerCfg_t dlyCfg;
  logic stepExpire;
  logic dlyExpire;

  // FSK borrows set one, so the ramp is pinned to set zero
  assign activeSet = fskOn ? 1'b0 : rampSel_q;
  assign stepCfg.divA = first_timer_divider;
  // second divider only counts when the host chose the ramp divider mode
  assign stepCfg.divB = rampDivMode ? rate_q[activeSet].second_timer_divider : 12'h001;
  assign dlyCfg.divA = dlyScaleOn ? first_timer_divider : 12'h001;
  assign dlyCfg.divB = regRaw_q[7][`RS_DLY_HI:`RS_DLY_LO];

  ramp_interval_timer stepTimer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tickEn(pfdTick_q),
    .restart(state_q != ramp_seq_pkg::ST_RAMP),
    .cfg(stepCfg),
    .expire(stepExpire)
  );

  ramp_interval_timer dlyTimer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tickEn(pfdTick_q),
    .restart(state_q != ramp_seq_pkg::ST_DELAY),
    .cfg(dlyCfg),
    .expire(dlyExpire)
  );

  // ----------------------------------------
  // ramp sequencer
  // ----------------------------------------
  logic [36:0] nDiv_q;
  logic [19:0] stepCnt_q;
  logic dirDown_q;
  logic sawRestore_q;
  logic gapDelay_q;
  logic [19:0] stepNext;
  logic signed [36:0] stepInc;
  logic legDone;

  assign stepNext = stepCnt_q + 20'h00001;
  // parabolic: increment grows with the step index
  assign stepInc = parabOn ?
    37'(devInc(rate_q[activeSet].devWord, rate_q[activeSet].devShift) *
        $signed({1'b0, stepNext})) :
    devInc(rate_q[activeSet].devWord, rate_q[activeSet].devShift);
  assign legDone = stepNext >= rate_q[activeSet].steps;

  // state walk; while ramping the divider only moves on a whole timer interval; idle tracks the base word
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ramp_seq_pkg::ST_IDLE;
      nDiv_q <= 37'h00_0000_0000;
      stepCnt_q <= 20'h00000;
      dirDown_q <= 1'b0;
      rampSel_q <= 1'b0;
      sawRestore_q <= 1'b0;
      gapDelay_q <= 1'b0;
    end else if (startPulse) begin
      nDiv_q <= baseDiv;
      stepCnt_q <= 20'h00000;
      dirDown_q <= 1'b0;
      rampSel_q <= 1'b0;
      sawRestore_q <= 1'b0;
      gapDelay_q <= 1'b0;
      state_q <= dlyStartOn ? ramp_seq_pkg::ST_DELAY : ramp_seq_pkg::ST_RAMP;
    end else if (!startBit) begin
      state_q <= ramp_seq_pkg::ST_IDLE;
      nDiv_q <= baseDiv;
      stepCnt_q <= 20'h00000;
      sawRestore_q <= 1'b0;
      gapDelay_q <= 1'b0;
    end else begin
      case (state_q)
        ramp_seq_pkg::ST_IDLE: begin
          nDiv_q <= baseDiv;
        end
        ramp_seq_pkg::ST_DELAY: begin
          if (dlyExpire) begin
            state_q <= ramp_seq_pkg::ST_RAMP;
            gapDelay_q <= 1'b0;
          end
        end
        ramp_seq_pkg::ST_RAMP: begin
          if (stepExpire && sawRestore_q) begin
            nDiv_q <= baseDiv;
            sawRestore_q <= 1'b0;
            stepCnt_q <= 20'h00000;
            if (waveType == ramp_seq_pkg::WAVE_SAW_BURST) begin
              state_q <= ramp_seq_pkg::ST_HOLD;
            end else begin
              rampSel_q <= dualOn ? !rampSel_q : 1'b0;
              if (dlyBetweenOn) begin
                state_q <= ramp_seq_pkg::ST_DELAY;
                gapDelay_q <= 1'b1;
              end
            end
          end else if (stepExpire) begin
            nDiv_q <= dirDown_q ? nDiv_q - stepInc : nDiv_q + stepInc;
            stepCnt_q <= stepNext;
            if (legDone) begin
              case (waveType)
                ramp_seq_pkg::WAVE_TRI: begin
                  // with dual rate off the count down equals the count up, so a cycle is twice the sweep
                  dirDown_q <= !dirDown_q;
                  stepCnt_q <= 20'h00000;
                  rampSel_q <= dualOn ? !rampSel_q : 1'b0;
                  if (dlyBetweenOn) begin
                    state_q <= ramp_seq_pkg::ST_DELAY;
                    gapDelay_q <= 1'b1;
                  end
                end
                ramp_seq_pkg::WAVE_RAMP_BURST: begin
                  state_q <= ramp_seq_pkg::ST_HOLD;
                end
                default: begin
                  sawRestore_q <= 1'b1;
                end
              endcase
            end
          end
        end
        ramp_seq_pkg::ST_HOLD: begin
          state_q <= ramp_seq_pkg::ST_HOLD;
        end
        default: begin
          state_q <= ramp_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // FSK data pin and outputs
  // ----------------------------------------
  logic [2:0] txSync_q;
  logic txLevel_q;

  // three flops; a change counts once the last two agree
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txSync_q <= 3'h0;
      txLevel_q <= 1'b0;
    end else begin
      txSync_q <= {txSync_q[1:0], txData};
      if (txSync_q[1] == txSync_q[2]) begin
        txLevel_q <= txSync_q[2];
      end
    end
  end

  // FSK offset rides on top of the ramp; the ramp itself is unaware of it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      nDivider <= 37'h00_0000_0000;
    end else if (fskOn && txLevel_q && state_q != ramp_seq_pkg::ST_IDLE) begin
      nDivider <= nDiv_q + devInc(rate_q[1].devWord, rate_q[1].devShift);
    end else begin
      nDivider <= nDiv_q;
    end
  end

  // fast lock covers the delay gap only, never the start delay
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fastLock <= 1'b0;
      rampActive <= 1'b0;
    end else begin
      fastLock <= fastLockOn && gapDelay_q && state_q == ramp_seq_pkg::ST_DELAY;
      rampActive <= state_q != ramp_seq_pkg::ST_IDLE;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  logic [31:0] rdMux;
  logic rdMapped;

  // live state is readable while the sweep runs
  always_comb begin
    rdMux = 32'h0000_0000;
    rdMapped = 1'b1;
    if (s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[1:0] == 2'h0) begin
      rdMux = regRaw_q[s_axi_araddr[4:2]];
    end else if (s_axi_araddr == `RS_OFF_STATUS) begin
      rdMux = {state_q, dirDown_q, rampSel_q, fastLock, 5'h00, stepCnt_q};
    end else if (s_axi_araddr == `RS_OFF_NDIV_LO) begin
      rdMux = nDivider[31:0];
    end else if (s_axi_araddr == `RS_OFF_NDIV_HI) begin
      rdMux = {27'h000_0000, nDivider[36:32]};
    end else begin
      rdMapped = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // one read at a time; data held until rready
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RS_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdMapped ? `RS_AXI_OKAY : `RS_AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ### bench/ramp_seq_checker.sv
// port-level assertions for the frequency ramp sequencer
module ramp_seq_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [36:0] nDivider,
  input wire logic rampActive,
  input wire logic fastLock
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // bus answers and sequencer outputs
  // ----------------------------------------
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("illegal write response");
  chk_reset_idle: assert property ($fell(sys_rst) |-> !rampActive && !fastLock
    && nDivider == 37'h0) else $error("outputs not cleared by reset");
  // a write reaches the divider two edges after bvalid rises
  chk_idle_still: assert property (!rampActive && !$past(rampActive) && !s_axi_bvalid
    && !$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2) |-> $stable(nDivider))
    else $error("divider moved while idle");
  chk_lock_active: assert property (fastLock |-> rampActive)
    else $error("fast lock outside a ramp");
endmodule

bind frequency_ramp_sequencer ramp_seq_checker chk_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .nDivider(nDivider), .rampActive(rampActive), .fastLock(fastLock)
);

// ### bench/host_axi_model.sv
// host controller model: AXI4-Lite master issuing one register access at a time
module host_axi_model (
  input wire logic clk_sys,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet bus from time zero
  initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
    s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  // all judged at the rising edge; each valid drops at the edge that takes it
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic [1:0] rs);
    rs = 2'h3;
    rd = 32'h0;
    @(posedge clk_sys);
    if (wr) begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
    end else begin
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      s_axi_araddr <= a;
    end
    for (int i = 0; i < 1000 && rs == 2'h3; i++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid : s_axi_rvalid) begin
        rs = wr ? s_axi_bresp : s_axi_rresp;
        rd = s_axi_rdata;
      end
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask
endmodule

// ### bench/frequency_ramp_sequencer_tb.sv
// self-checking bench of the frequency ramp sequencer
`include "ramp_seq_params.svh"
module frequency_ramp_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RATIO = 2;
  localparam logic [36:0] BASE = 37'h0002000000;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic txData = 1'b0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rampActive, fastLock;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsv;
  logic [36:0] nDivider;
  int error_cnt = 0;
  int checks = 0;
  int gapSeen, d1;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] rd; logic [1:0] rs;} row_t;
  // host write order, delay down to int word, then unmapped
  row_t rows [11] = '{'{8'h1C, 32'h28, 32'h28, 2'h0}, '{8'h18, 32'h800010, 32'h800010, 2'h0},
    '{8'h18, 32'h18, 32'h18, 2'h0}, '{8'h14, 32'h800010, 32'h800010, 2'h0},
    '{8'h14, 32'h8, 32'h8, 2'h0}, '{8'h10, 32'h180180, 32'h180180, 2'h0},
    '{8'h0C, 32'h0, 32'h0, 2'h0}, '{8'h08, 32'h10, 32'h10, 2'h0}, '{8'h04, 32'h0, 32'h0, 2'h0},
    '{8'h00, 32'h8000, 32'h8000, 2'h0}, '{8'h2C, 32'hFFFFFFFF, 32'h0, 2'h2}};
  always #5 clk_sys = ~clk_sys;
  frequency_ramp_sequencer #(.PFD_RATIO(RATIO)) dut_u (.clk_sys, .sys_rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .txData, .nDivider, .rampActive,
    .fastLock);
  host_axi_model host_u (.clk_sys, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, rdv, rsv);
    chk("bresp", 64'(rsv), 64'(`RS_AXI_OKAY));
  endtask
  task automatic state(input logic [3:0] exp);
    host_u.xfer(1'b0, 8'h20, 32'h0, rdv, rsv);
    chk("state", 64'(rdv[31:28]), 64'(exp));
  endtask
  // divider changes in turn; gap in cycles since the last one
  task automatic sweep(input int v[$]);
    logic [36:0] prev;
    @(posedge clk_sys);
    #1;
    foreach (v[i]) begin
      prev = nDivider;
      gapSeen = 0;
      while (nDivider === prev && gapSeen < 4000) begin
        @(posedge clk_sys);
        #1;
        gapSeen++;
      end
      chk("nDivider", 64'(nDivider), 64'(BASE + 37'(v[i])));
      if (i > 0) chk("hop gap", 64'(gapSeen), 64'(2 * 3 * RATIO));
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("idle nDivider", 64'(nDivider), 64'h0);
    state(4'h1);
    foreach (rows[i]) begin
      host_u.xfer(1'b1, rows[i].a, rows[i].d, rdv, rsv);
      chk("bresp", 64'(rsv), 64'(rows[i].rs));
      host_u.xfer(1'b0, rows[i].a, 32'h0, rdv, rsv);
      chk("rdata", 64'(rdv), 64'(rows[i].rd));
      chk("rresp", 64'(rsv), 64'(rows[i].rs));
    end
    wr(8'h00, 32'h80008000);
    sweep('{1, 2, 3, 0, 1});
    chk("rampActive", 64'(rampActive), 64'h1);
    wr(8'h0C, 32'h400);
    wr(8'h00, 32'h80008000);
    sweep('{1, 2, 3, 2, 1, 0});
    wr(8'h14, 32'h10000008);
    wr(8'h0C, 32'hC00);
    wr(8'h00, 32'h80008000);
    sweep('{1, 3, 6});
    repeat (40) @(posedge clk_sys);
    state(4'h8);
    wr(8'h00, 32'h8000);
    state(4'h1);
    chk("stopped nDivider", 64'(nDivider), 64'(BASE));
    wr(8'h14, 32'h8);
    wr(8'h0C, 32'h0);
    wr(8'h1C, 32'h8028);
    wr(8'h00, 32'h80008000);
    state(4'h2);
    sweep('{1});
    d1 = gapSeen;
    wr(8'h1C, 32'h18028);
    wr(8'h00, 32'h80008000);
    state(4'h2);
    sweep('{1});
    chk("scaled delay", 64'((gapSeen - d1) inside {[8:12]}), 64'h1);
    wr(8'h1C, 32'h60028);
    wr(8'h00, 32'h80008000);
    for (int i = 0; i < 400 && fastLock !== 1'b1; i++) @(posedge clk_sys);
    chk("fastLock", 64'(fastLock), 64'h1);
    state(4'h2);
    wr(8'h1C, 32'h0);
    wr(8'h08, 32'h7FF8);
    wr(8'h14, 32'h2800040);
    wr(8'h14, 32'h2000008);
    wr(8'h00, 32'h80008000);
    @(posedge clk_sys);
    txData <= 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    chk("fsk high", 64'(nDivider), 64'(BASE + 37'h8));
    @(posedge clk_sys);
    txData <= 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    chk("fsk low", 64'(nDivider), 64'(BASE));
    wr(8'h00, 32'h8000);
    summarize();
  end
  // hang guard
  initial begin
    repeat (30000) @(posedge clk_sys);
    error_cnt++;
    summarize();
  end
endmodule
